// ==== inc/tmc_params.svh ====
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// APB byte offsets of the register words
`define TMC_OFS_CTRL 12'h000
`define TMC_OFS_LOW 12'h004
`define TMC_OFS_HIGH 12'h008
`define TMC_OFS_STAT 12'h00c
`define TMC_OFS_MASK 12'h010

// Field positions inside the words
`define TMC_POS_SYSOSC 6
`define TMC_POS_OVF 0

// Reset values
`define TMC_CTRL_RST 8'h00
`define TMC_COUNT_RST 16'h0000
`define TMC_MASK_RST 1'b0

// Control bits software may write; the clock status bit is read-only
`define TMC_CTRL_WMASK 8'hbf

// Internal source runs at the core clock divided by this
`define TMC_QUARTER_DIV 4
`define TMC_QUARTER_LAST (`TMC_QUARTER_DIV - 1)

`endif

// ==== inc/tmc_pkg.sv ====
`default_nettype none

package tmc_pkg;

   // Control word, bit 7 first
   typedef struct packed {
      logic wide_access_select;
      logic system_clock_from_osc;
      logic [1:0] input_divide_select;
      logic own_osc_enable;
      logic external_sync_select;
      logic count_source_select;
      logic count_run;
   } tmc_ctrl_s;

   // The 16-bit count as its two byte registers
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } tmc_count_s;

   // One-hot register selector from the address decoder
   typedef enum logic [5:0] {
      TMC_REG_NONE = 6'b000001,
      TMC_REG_CTRL = 6'b000010,
      TMC_REG_LOW = 6'b000100,
      TMC_REG_HIGH = 6'b001000,
      TMC_REG_STAT = 6'b010000,
      TMC_REG_MASK = 6'b100000
   } tmc_reg_e;

endpackage

`default_nettype wire

// ==== hw/tmc_tick_source.sv ====
`include "tmc_params.svh"
`default_nettype none

module tmc_tick_source
   import tmc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Configuration and prescaler clear
   input wire tmc_ctrl_s ctrl,
   input wire logic presc_clear,
   // Raw inputs from outside the clock domain
   input wire logic external_count_pin,
   input wire logic osc_clk_in,
   // One-cycle increment request
   output logic tick
);

   logic [1:0] quarter_cnt; // Instruction-cycle phase
   logic quarter_en; // Fosc/4 enable pulse
   logic [1:0] sync_a; // First synchroniser stages, oscillator above pin
   logic [1:0] sync_b; // Second synchroniser stages
   logic sel_lvl; // Synchronised level of the chosen input
   logic sync_prev; // Last selected level
   logic ext_rise; // Rising edge in core domain
   logic ext_pend; // Edge waiting for the next instruction cycle
   logic src_event; // Selected source event
   logic [2:0] ps_cnt; // Prescaler count

   // Last prescaler count for a divide select of 1, 2, 4 or 8
   function automatic logic [2:0] div_last(input logic [1:0] sel);
      div_last = 3'((4'd1 << sel) - 4'd1);
   endfunction

   // Free-running divide by four for the internal source
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         quarter_cnt <= 2'd0;
      end else if (quarter_en) begin
         quarter_cnt <= 2'd0;
      end else begin
         quarter_cnt <= quarter_cnt + 2'd1;
      end
   end
   assign quarter_en = (quarter_cnt == 2'(`TMC_QUARTER_LAST));

   // Both inputs pass two stages before the source mux reads them
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync_a <= 2'b00;
         sync_b <= 2'b00;
         sync_prev <= 1'b0;
      end else begin
         sync_a <= {osc_clk_in, external_count_pin};
         sync_b <= sync_a;
         sync_prev <= sel_lvl;
      end
   end

   // The enabled oscillator takes over the pin as count input
   // Switching source while the new line is high shows one edge
   assign sel_lvl = ctrl.own_osc_enable ? sync_b[1] : sync_b[0];
   assign ext_rise = sel_lvl & ~sync_prev;

   // Synchronised mode counts an edge only on an instruction cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ext_pend <= 1'b0;
      end else if (quarter_en) begin
         ext_pend <= 1'b0;
      end else if (ext_rise) begin
         ext_pend <= 1'b1;
      end
   end

   // Source selection
   always_comb begin
      if (!ctrl.count_source_select) begin
         // Internal clock; the sync select has no meaning here
         src_event = quarter_en;
      end else if (ctrl.external_sync_select) begin
         // Unsynchronised: count at the detected edge itself
         src_event = ext_rise;
      end else begin
         // Synchronised: align the edge to the instruction cycle
         src_event = quarter_en & (ext_pend | ext_rise);
      end
   end

   // Prescaler; a stale count above a new limit just wraps
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ps_cnt <= 3'd0;
      end else if (presc_clear) begin
         ps_cnt <= 3'd0;
      end else if (ctrl.count_run && src_event) begin
         if (ps_cnt >= div_last(ctrl.input_divide_select)) begin
            ps_cnt <= 3'd0;
         end else begin
            ps_cnt <= ps_cnt + 3'd1;
         end
      end
   end

   // Halted counter gets no increments
   assign tick = ctrl.count_run && src_event &&
                 (ps_cnt >= div_last(ctrl.input_divide_select));

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   a_low_wr_clears_ps: assert property (presc_clear |=> ps_cnt == 3'd0)
      else $error("prescaler not cleared by low byte write");

   a_int_tick_spacing: assert property (
      tick && !ctrl.count_source_select |=> (!tick || ctrl.count_source_select) [*3])
      else $error("internal source ticks faster than one in four");

   a_sync_on_quarter: assert property (
      ctrl.count_source_select && !ctrl.external_sync_select && src_event |-> quarter_en)
      else $error("synchronised event off the instruction cycle");

endmodule

`default_nettype wire

// ==== hw/tmc_timer.sv ====
// Functional notes
// - Sixteen-bit counter, timer or event counter
// - Count readable and writable as two bytes
// - Compare trigger clears the count
// - Own low-power oscillator as count source
// - Control bit 0 runs or halts counting
// - Control bit 7 selects 16-bit access
// - Control bit 6 shows system clock source
// - Control bits 5-4 select input prescale
// - Control bit 3 enables own oscillator
// - Bit 2 chooses synchronised or unsynchronised external
// - Internal source ignores the sync bit
// - Bit 1 selects external edges or Fosc/4
// - Count wraps upward, wrap latches overflow flag
// - Wide mode buffers high byte via low access
// - Only low byte writes clear the prescaler
// - Count write wins over compare trigger
`include "tmc_params.svh"
`default_nettype none

module tmc_timer
   import tmc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Count inputs from outside the chip
   input wire logic external_count_pin,
   input wire logic osc_clk_in,
   // Oscillator power control
   output logic osc_enable,
   // Core-domain inputs from the clock and compare logic
   input wire logic system_clock_from_osc,
   input wire logic compare_trigger,
   // Interrupt
   output logic irq
);

   tmc_ctrl_s ctrl; // Control word
   tmc_count_s count; // Live count
   logic [7:0] high_buffer; // High byte buffer for wide access
   logic ovf_flag; // Sticky overflow status
   logic ovf_mask; // Overflow interrupt enable
   logic tick; // Increment request from the source
   tmc_reg_e sel; // Decoded register of the current address
   logic setup_rd; // Read in its setup cycle
   logic wr_acc; // Write in its access cycle
   logic rd_acc; // Read in its access cycle
   logic wr_low; // Low byte write
   logic wr_high; // High byte write, either mode
   logic wr_high_direct; // High byte write in byte mode
   logic count_wrap; // Count steps from all ones to zero
   logic [31:0] next_prdata; // Read word for the decoded address
   tmc_ctrl_s ctrl_view; // Control word as software sees it

   // Address decode, shared by the setup and the access cycle
   function automatic tmc_reg_e reg_decode(input logic [11:0] addr);
      case (addr)
         `TMC_OFS_CTRL: reg_decode = TMC_REG_CTRL;
         `TMC_OFS_LOW: reg_decode = TMC_REG_LOW;
         `TMC_OFS_HIGH: reg_decode = TMC_REG_HIGH;
         `TMC_OFS_STAT: reg_decode = TMC_REG_STAT;
         `TMC_OFS_MASK: reg_decode = TMC_REG_MASK;
         default: reg_decode = TMC_REG_NONE;
      endcase
   endfunction

   // Bus phase decode
   assign sel = reg_decode(paddr);
   assign setup_rd = psel & ~penable & ~pwrite;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign wr_low = wr_acc && (sel == TMC_REG_LOW);
   assign wr_high = wr_acc && (sel == TMC_REG_HIGH);
   assign wr_high_direct = wr_high && !ctrl.wide_access_select;

   // Read data is built in setup, so every access ends in one cycle
   assign pready = 1'b1;

   // Source selection, synchronisers and prescaler
   tmc_tick_source u_source (
      .mclk(mclk),
      .rst(rst),
      .ctrl(ctrl),
      .presc_clear(wr_low),
      .external_count_pin(external_count_pin),
      .osc_clk_in(osc_clk_in),
      .tick(tick)
   );

   // Control register; the clock status bit is never stored
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl <= tmc_ctrl_s'(`TMC_CTRL_RST);
      end else if (wr_acc && sel == TMC_REG_CTRL) begin
         ctrl <= tmc_ctrl_s'(pwdata[7:0] & `TMC_CTRL_WMASK);
      end
   end

   // The oscillator draws no power unless enabled
   assign osc_enable = ctrl.own_osc_enable;

   // Readback shows the live clock source in bit 6
   always_comb begin
      ctrl_view = ctrl;
      ctrl_view.system_clock_from_osc = system_clock_from_osc;
   end

   // A wrap only counts when no write or trigger replaces the step
   assign count_wrap = tick && (count == 16'hffff) && !wr_low &&
                       !wr_high_direct && !compare_trigger;

   // Counter: writes first, then the trigger, then the increment
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count <= tmc_count_s'(`TMC_COUNT_RST);
      end else if (wr_low) begin
         // Low write wins over a coincident trigger
         count.low <= pwdata[7:0];
         if (ctrl.wide_access_select) begin
            count.high <= high_buffer;
         end
      end else if (wr_high_direct) begin
         count.high <= pwdata[7:0];
      end else if (compare_trigger) begin
         // Trigger clears but never raises the overflow flag
         count <= tmc_count_s'(`TMC_COUNT_RST);
      end else if (tick) begin
         count <= tmc_count_s'(count + 16'h0001);
      end
   end

   // High byte buffer: a low read snapshots the live high byte
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         high_buffer <= 8'h00;
      end else if (setup_rd && sel == TMC_REG_LOW && ctrl.wide_access_select) begin
         // Taken in the same edge as the low byte, so no rollover tear
         high_buffer <= count.high;
      end else if (wr_high && ctrl.wide_access_select) begin
         high_buffer <= pwdata[7:0];
      end
   end

   // Overflow flag: a wrap wins over a clear by read
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ovf_flag <= 1'b0;
      end else if (count_wrap) begin
         ovf_flag <= 1'b1;
      end else if (rd_acc && sel == TMC_REG_STAT && prdata[`TMC_POS_OVF]) begin
         // Only a flag that software has actually seen is cleared
         ovf_flag <= 1'b0;
      end
   end

   // Interrupt mask
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ovf_mask <= `TMC_MASK_RST;
      end else if (wr_acc && sel == TMC_REG_MASK) begin
         ovf_mask <= pwdata[`TMC_POS_OVF];
      end
   end

   // Level interrupt while an enabled flag is pending
   assign irq = ovf_flag & ovf_mask;

   // Read word for the addressed register
   always_comb begin
      next_prdata = 32'h0000_0000;
      case (sel)
         TMC_REG_CTRL: next_prdata[7:0] = ctrl_view;
         TMC_REG_LOW: next_prdata[7:0] = count.low;
         TMC_REG_HIGH: begin
            // Wide mode reads the buffer, byte mode the live byte
            next_prdata[7:0] = ctrl.wide_access_select ? high_buffer : count.high;
         end
         TMC_REG_STAT: next_prdata[`TMC_POS_OVF] = ovf_flag;
         TMC_REG_MASK: next_prdata[`TMC_POS_OVF] = ovf_mask;
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup cycle and held through access
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata <= next_prdata;
      end
   end

   // Unmapped addresses answer with an error, reads give zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= (sel == TMC_REG_NONE);
      end else if (psel && penable) begin
         pslverr <= 1'b0;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   a_wrap_sets_flag: assert property (
      count_wrap |=> count == tmc_count_s'(16'h0000) && ovf_flag)
      else $error("wrap did not reach zero with overflow set");

   a_halt_holds_count: assert property (
      !ctrl.count_run && !wr_low && !wr_high_direct && !compare_trigger
      |=> $stable(count))
      else $error("halted counter changed");

   a_trigger_clears: assert property (
      compare_trigger && !wr_low && !wr_high_direct
      |=> count == tmc_count_s'(16'h0000) && !$rose(ovf_flag))
      else $error("compare trigger did not clear the count");

   a_write_beats_trig: assert property (
      wr_low && compare_trigger |=> count.low == $past(pwdata[7:0]))
      else $error("trigger overrode a low byte write");

   a_wide_low_load: assert property (
      wr_low && ctrl.wide_access_select |=> count.high == $past(high_buffer))
      else $error("low write did not load high byte from buffer");

   a_low_read_snap: assert property (
      setup_rd && sel == TMC_REG_LOW && ctrl.wide_access_select
      |=> high_buffer == $past(count.high) && prdata[7:0] == $past(count.low))
      else $error("low read did not snapshot the high byte");

   a_narrow_high_wr: assert property (
      wr_high_direct |=> count.high == $past(pwdata[7:0]))
      else $error("byte mode high write not applied");

   a_status_bit_live: assert property (
      setup_rd && sel == TMC_REG_CTRL
      |=> prdata[`TMC_POS_SYSOSC] == $past(system_clock_from_osc)
          && !ctrl.system_clock_from_osc)
      else $error("clock status bit does not follow its source");

   a_high_keeps_ps: assert property (
      wr_high && u_source.ps_cnt != 3'd0 && !tick |=> u_source.ps_cnt != 3'd0)
      else $error("high byte write cleared the prescaler");

   c_wrap: cover property (count_wrap);
   c_trigger: cover property (compare_trigger && ctrl.count_run);
   c_wide_write: cover property (wr_low && ctrl.wide_access_select);
   c_irq_raised: cover property ($rose(irq));

endmodule

`default_nettype wire

// ==== verification/tmc_ext_source.sv ====
`default_nettype none

module tmc_ext_source
   import tmc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Burst request from the bench
   input wire logic go,
   input wire logic use_osc,
   input wire logic [7:0] edges,
   input wire logic [3:0] half,
   // Clock lines toward the timer, busy toward the bench
   output logic pin_out,
   output logic osc_out,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;

   logic level; // Level of the burst clock
   logic [7:0] left; // Pulses still to send
   logic [3:0] cnt; // Cycles spent in this half period

   // Burst generator; half must be 3 or more so the sync flops see each level
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         level <= 1'b0;
         left <= 8'h00;
         cnt <= 4'h0;
      end else if (go && !busy) begin
         busy <= 1'b1;
         level <= 1'b0;
         left <= edges;
         cnt <= 4'h0;
      end else if (busy) begin
         if (cnt == half - 4'h1) begin
            cnt <= 4'h0;
            level <= ~level;
            // A burst ends at the fall that closes the high half of its last pulse
            if (level && left == 8'h01) begin
               busy <= 1'b0;
            end
            if (level) begin
               left <= left - 8'h01;
            end
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end

   // Only the chosen line moves; both rest low between bursts
   assign pin_out = busy & level & ~use_osc;
   assign osc_out = busy & level & use_osc;

endmodule

`default_nettype wire

// ==== verification/tb.sv ====
`include "tmc_params.svh"
`default_nettype none

module tb
   import tmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // Bench drive, all set at time zero
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic sys_osc = 1'b0; // Clock-status input
   logic cmp = 1'b0; // Compare trigger pulse
   logic go = 1'b0;
   logic use_osc = 1'b0;
   logic [7:0] edges = 8'h00;
   logic [3:0] half = 4'h3;
   // Design and partner outputs
   logic [31:0] prdata;
   logic pready, pslverr, osc_enable, irq, pin, osc, busy;
   // Bookkeeping
   int fail_count = 0;
   int num_checks = 0;
   logic [31:0] rd, v;
   logic er;
   int i, n;

   tmc_timer dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_count_pin(pin),
      .osc_clk_in(osc), .osc_enable(osc_enable),
      .system_clock_from_osc(sys_osc), .compare_trigger(cmp), .irq(irq));

   tmc_ext_source src_u (.mclk(mclk), .rst(rst), .go(go), .use_osc(use_osc),
      .edges(edges), .half(half), .pin_out(pin), .osc_out(osc), .busy(busy));

   // 100 MHz core clock
   initial begin
      forever #5 mclk = ~mclk;
   end

   // Verdict; the only place the run ends
   task final_report;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Exact compare; four-state so an unknown never matches
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Range compare, for counts whose phase against the divider is free
   task chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] got);
      num_checks++;
      if ((got >= lo && got <= lo + 32'd2) !== 1'b1) begin
         fail_count++;
         $display("MISMATCH %s expected %h..+2 seen %h", nm, lo, got);
      end
   endtask

   // One APB transfer; t raises the compare trigger in the access cycle
   task xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic t);
      int k;
      @(posedge mclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      cmp <= t;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      cmp <= 1'b0;
      if (k >= 50) begin
         fail_count++;
         final_report;
      end
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d, 1'b0);
   endtask

   task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0, 1'b0);
      chk(nm, exp, rd);
   endtask

   // One burst of edges from the partner, waited out with margin
   task burst(input logic o, input logic [3:0] h, input logic [7:0] e);
      use_osc <= o;
      half <= h;
      edges <= e;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      wait_for(1'b0);
      repeat (10) @(posedge mclk);
   endtask

   // Bounded wait for irq, or for the burst to finish
   task wait_for(input logic want_irq);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while ((want_irq ? irq !== 1'b1 : busy !== 1'b0) && n < 300);
      if (n >= 300) begin
         fail_count++;
         final_report;
      end
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      // Reset state
      chk("irq_rst", 32'h0, {31'h0, irq});
      rdchk("ctrl_rst", `TMC_OFS_CTRL, 32'h00);
      rdchk("low_rst", `TMC_OFS_LOW, 32'h00);
      rdchk("high_rst", `TMC_OFS_HIGH, 32'h00);
      rdchk("stat_rst", `TMC_OFS_STAT, 32'h00);
      rdchk("mask_rst", `TMC_OFS_MASK, 32'h00);
      // Control word, status bit follows its input only
      wr(`TMC_OFS_CTRL, 32'hff);
      rdchk("ctrl_ro", `TMC_OFS_CTRL, 32'hbf);
      chk("osc_on", 32'h1, {31'h0, osc_enable});
      sys_osc <= 1'b1;
      wr(`TMC_OFS_CTRL, 32'h00);
      rdchk("ctrl_sys", `TMC_OFS_CTRL, 32'h40);
      chk("osc_off", 32'h0, {31'h0, osc_enable});
      sys_osc <= 1'b0;
      // Byte mode, then compare trigger, then write against trigger
      wr(`TMC_OFS_LOW, 32'h34);
      wr(`TMC_OFS_HIGH, 32'h12);
      rdchk("low_b", `TMC_OFS_LOW, 32'h34);
      rdchk("high_b", `TMC_OFS_HIGH, 32'h12);
      @(posedge mclk);
      cmp <= 1'b1;
      @(posedge mclk);
      cmp <= 1'b0;
      rdchk("low_trig", `TMC_OFS_LOW, 32'h00);
      rdchk("high_trig", `TMC_OFS_HIGH, 32'h00);
      xfer(`TMC_OFS_LOW, 1'b1, 32'h55, 1'b1);
      rdchk("low_win", `TMC_OFS_LOW, 32'h55);
      // Wide mode: high write waits in the buffer until the low write
      wr(`TMC_OFS_HIGH, 32'h00);
      wr(`TMC_OFS_CTRL, 32'h80);
      wr(`TMC_OFS_HIGH, 32'hab);
      wr(`TMC_OFS_CTRL, 32'h00);
      rdchk("high_held", `TMC_OFS_HIGH, 32'h00);
      wr(`TMC_OFS_CTRL, 32'h80);
      wr(`TMC_OFS_LOW, 32'hcd);
      rdchk("low_w", `TMC_OFS_LOW, 32'hcd);
      rdchk("high_snap", `TMC_OFS_HIGH, 32'hab);
      // A low read must copy a live high byte that differs from the buffer
      wr(`TMC_OFS_CTRL, 32'h00);
      wr(`TMC_OFS_HIGH, 32'h77);
      wr(`TMC_OFS_CTRL, 32'h80);
      rdchk("low_snap", `TMC_OFS_LOW, 32'hcd);
      rdchk("high_live", `TMC_OFS_HIGH, 32'h77);
      wr(`TMC_OFS_CTRL, 32'h00);
      // Internal rate for every prescale, sync bit both ways
      for (i = 0; i < 8; i++) begin
         wr(`TMC_OFS_LOW, 32'h00);
         wr(`TMC_OFS_HIGH, 32'h00);
         wr(`TMC_OFS_CTRL, 32'((i % 4) << 4 | (i / 4) << 2 | 1));
         repeat (256) @(posedge mclk);
         wr(`TMC_OFS_CTRL, 32'h00);
         xfer(`TMC_OFS_LOW, 1'b0, 32'h0, 1'b0);
         chk_rng("rate", 32'(64 >> (i % 4)), rd);
      end
      // Halted count holds
      v = rd;
      repeat (20) @(posedge mclk);
      rdchk("halt", `TMC_OFS_LOW, v);
      // Overflow with interrupt enabled, cleared by reading status
      wr(`TMC_OFS_MASK, 32'h01);
      wr(`TMC_OFS_HIGH, 32'hff);
      wr(`TMC_OFS_LOW, 32'hfe);
      wr(`TMC_OFS_CTRL, 32'h01);
      wait_for(1'b1);
      wr(`TMC_OFS_CTRL, 32'h00);
      rdchk("stat_set", `TMC_OFS_STAT, 32'h01);
      rdchk("stat_clr", `TMC_OFS_STAT, 32'h00);
      @(posedge mclk);
      chk("irq_clr", 32'h0, {31'h0, irq});
      // Overflow masked: flag latches, line stays low
      wr(`TMC_OFS_MASK, 32'h00);
      wr(`TMC_OFS_HIGH, 32'hff);
      wr(`TMC_OFS_LOW, 32'hfe);
      wr(`TMC_OFS_CTRL, 32'h01);
      repeat (40) @(posedge mclk);
      chk("irq_mask", 32'h0, {31'h0, irq});
      wr(`TMC_OFS_CTRL, 32'h00);
      rdchk("stat_mask", `TMC_OFS_STAT, 32'h01);
      // External edges from pin and oscillator, synced and not
      for (i = 0; i < 4; i++) begin
         wr(`TMC_OFS_LOW, 32'h00);
         wr(`TMC_OFS_HIGH, 32'h00);
         wr(`TMC_OFS_CTRL, 32'(3 | (i % 2) << 2 | (i / 2) << 3));
         burst(i / 2 == 1, (i % 2 == 1) ? 4'h8 : 4'h3, 8'h05);
         wr(`TMC_OFS_CTRL, 32'h00);
         rdchk("ext_cnt", `TMC_OFS_LOW, 32'h05);
      end
      // Prescale 8 on unsynchronised edges: 5 edges, high write, 3 more
      wr(`TMC_OFS_LOW, 32'h00);
      wr(`TMC_OFS_CTRL, 32'h37);
      burst(1'b0, 4'h8, 8'h05);
      wr(`TMC_OFS_HIGH, 32'h00);
      burst(1'b0, 4'h8, 8'h03);
      wr(`TMC_OFS_CTRL, 32'h00);
      rdchk("ps_kept", `TMC_OFS_LOW, 32'h01);
      // Unmapped address: refused, read as zero, write lost
      xfer(12'h020, 1'b0, 32'h0, 1'b0);
      chk("unm_data", 32'h0, rd);
      chk("unm_err", 32'h1, {31'h0, er});
      wr(12'h020, 32'hff);
      rdchk("unm_wr", `TMC_OFS_CTRL, 32'h00);
      chk("map_err", 32'h0, {31'h0, er});
      final_report;
   end

endmodule

`default_nettype wire
